// ### src/pamx_top.sv
// port a pin function multiplexer with apb register file
// assumes pins are outside the pclk domain; peripheral sources are on pclk
//
// Behaviour
// - bit 7 drives latch; released in external oscillator
// - bit 7 reads pin; disabled in external oscillator
// - external clock follows crystal input, ignoring direction
// - only highest priority enabled source drives pin
// - fixed per-bit priority: dac, sr, comparator, osc
// - analog inputs stay out of output arbitration
// - digital outputs still drive pins in analog mode
// - unimplemented bits read zero, writes ignored
// - analog select disables the digital input buffer
// - bit 6 latch only internal oscillator, no clockout
// - rc mode clock out is crystal input over four
//
// The address map and the APB slave port are this design's own decisions.
`include "pamx_map.svh"

module pamx_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic                   [31:0] paddr,
    input  wire logic                   [31:0] pwdata,
    output logic                        [31:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                    [7:0] port_a_pin_in,
    output logic                         [7:0] port_a_pin_out,
    output logic                         [7:0] port_a_pin_oe,
    input  wire logic                          dac_output_en,
    input  wire logic                          sr_latch_q,
    input  wire logic                          sr_latch_q_en,
    input  wire logic                          sr_latch_q_inverted,
    input  wire logic                          sr_latch_q_inverted_en,
    input  wire logic                          comparator1_output,
    input  wire logic                          comparator1_output_en,
    input  wire logic                          comparator2_output,
    input  wire logic                          comparator2_output_en,
    output logic                               external_clock_in,
    output logic                               dac_output_connect,
    output logic                               crystal_out_connect,
    output logic                         [7:0] port_a_analog_enable,
    output logic                         [4:0] slew_rate_limit
);
    import pamx_pkg::*;

    // register file
    logic           [7:0] ansel_ff;
    logic           [7:0] nxt_ansel;
    logic           [7:0] latch_ff;
    logic           [7:0] nxt_latch;
    logic           [7:0] dir_ff;
    logic           [7:0] nxt_dir;
    logic           [7:0] slew_ff;
    logic           [7:0] nxt_slew;
    pamx_osc_mode_t       osc_ff;
    pamx_osc_mode_t       nxt_osc;

    // bus answer
    logic          [31:0] prdata_ff;
    logic          [31:0] nxt_prdata;
    logic                 pready_ff;
    logic                 nxt_pready;
    logic                 pslverr_ff;
    logic                 nxt_pslverr;

    // pin sampling; meta stage is read only by the sync stage
    logic           [7:0] pin_meta_ff;
    logic           [7:0] pin_sync_ff;
    logic                 xin_prev_ff;
    logic                 nxt_xin_prev;

    // clock-out divider
    logic           [1:0] div_cnt_ff;
    logic           [1:0] nxt_div_cnt;
    logic                 clk_out_ff;
    logic                 nxt_clk_out;

    // pin outputs
    logic           [7:0] pin_out_ff;
    logic           [7:0] pin_oe_ff;
    logic                 ext_clk_ff;
    logic                 dac_conn_ff;
    logic                 xtal_conn_ff;

    // arbitration results
    logic           [7:0] arb_val;
    logic           [7:0] arb_oe;
    logic           [7:0] arb_in_en;
    logic                 arb_dac;
    logic                 arb_xtal;

    logic                 setup_ph;
    logic                 wr_take;
    logic           [7:0] addr_lo;
    logic           [7:0] wbyte;
    logic           [7:0] pins_view;
    logic                 mapped;
    logic                 div_tick;
    logic                 addr_in_range;

    function automatic logic [31:0] pamx_zext(input logic [7:0] v);
        return {24'h000000, v};
    endfunction : pamx_zext

    assign setup_ph  = psel && !penable;
    assign addr_in_range = (paddr[31:8] == 24'h000000);
    // out-of-range writes are dropped too
    assign wr_take   = psel && penable && pready_ff && pwrite && addr_in_range;
    assign addr_lo   = paddr[7:0];
    assign wbyte     = pwdata[7:0];
    assign pins_view = pin_sync_ff & arb_in_en;

    // arbitration is combinational
    pamx_pin_arb u_arb (
        .latch                  (latch_ff),
        .dir                    (dir_ff),
        .ansel                  (ansel_ff),
        .osc_mode               (osc_ff),
        .clk_out_level          (clk_out_ff),
        .dac_output_en          (dac_output_en),
        .sr_latch_q             (sr_latch_q),
        .sr_latch_q_en          (sr_latch_q_en),
        .sr_latch_q_inverted    (sr_latch_q_inverted),
        .sr_latch_q_inverted_en (sr_latch_q_inverted_en),
        .comparator1_output     (comparator1_output),
        .comparator1_output_en  (comparator1_output_en),
        .comparator2_output     (comparator2_output),
        .comparator2_output_en  (comparator2_output_en),
        .pin_val                (arb_val),
        .pin_oe                 (arb_oe),
        .dig_in_en              (arb_in_en),
        .dac_connect            (arb_dac),
        .xtal_out_connect       (arb_xtal)
    );

    // register writes; pins and latch offsets both land in the latch
    always_comb begin
        nxt_ansel = ansel_ff;
        nxt_latch = latch_ff;
        nxt_dir   = dir_ff;
        nxt_slew  = slew_ff;
        nxt_osc   = osc_ff;

        if (wr_take) begin
            unique case (addr_lo)
                `PAMX_OFF_ANSEL: nxt_ansel = wbyte & `PAMX_ANSEL_MASK;
                `PAMX_OFF_PINS:  nxt_latch = wbyte;
                `PAMX_OFF_LATCH: nxt_latch = wbyte;
                `PAMX_OFF_DIR:   nxt_dir   = wbyte;
                `PAMX_OFF_SLEW:  nxt_slew  = wbyte & `PAMX_SLEW_MASK;
                `PAMX_OFF_OSC:   nxt_osc   = pamx_osc_mode_t'(
                    wbyte[`PAMX_OSC_MODE_LSB +: `PAMX_OSC_MODE_W]);
                default: ;
            endcase
        end
    end

    // dir resets to ones: pins wake as inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ansel_ff <= `PAMX_ANSEL_RST;
            latch_ff <= `PAMX_LATCH_RST;
            dir_ff   <= `PAMX_DIR_RST;
            slew_ff  <= `PAMX_SLEW_RST;
            osc_ff   <= PAMX_OSC_INT;
        end else begin
            ansel_ff <= nxt_ansel;
            latch_ff <= nxt_latch;
            dir_ff   <= nxt_dir;
            slew_ff  <= nxt_slew;
            osc_ff   <= nxt_osc;
        end
    end

    // read data is formed in setup, so the access phase never waits
    always_comb begin
        mapped      = 1'b1;
        nxt_prdata  = 32'h00000000;
        unique case (addr_lo)
            `PAMX_OFF_ANSEL:  nxt_prdata = pamx_zext(ansel_ff);
            `PAMX_OFF_PINS:   nxt_prdata = pamx_zext(pins_view);
            `PAMX_OFF_LATCH:  nxt_prdata = pamx_zext(latch_ff);
            `PAMX_OFF_DIR:    nxt_prdata = pamx_zext(dir_ff);
            `PAMX_OFF_SLEW:   nxt_prdata = pamx_zext(slew_ff);
            `PAMX_OFF_OSC:    nxt_prdata = pamx_zext({6'h00, osc_ff});
            `PAMX_OFF_STATUS: begin
                nxt_prdata[`PAMX_STAT_CLKOUT_BIT] = clk_out_ff;
                nxt_prdata[`PAMX_STAT_EXT_BIT]    = pamx_is_external(osc_ff);
                nxt_prdata[`PAMX_STAT_DAC_BIT]    = dac_conn_ff;
            end
            default: mapped = 1'b0;
        endcase

        if (!addr_in_range) begin
            mapped     = 1'b0;
            nxt_prdata = 32'h00000000;
        end
        // stale read data never leaks
        if (!setup_ph || pwrite) begin
            nxt_prdata = 32'h00000000;
        end

        nxt_pready  = setup_ph;
        nxt_pslverr = setup_ph && !mapped;
    end

    // zero wait states: one pready pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // two-stage pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= 8'h00;
            pin_sync_ff <= 8'h00;
        end else begin
            pin_meta_ff <= port_a_pin_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // rc: count crystal-in rising edges; internal: count pclk edges.
    // a pclk-sampled crystal input above pclk/2 cannot be divided faithfully
    always_comb begin
        nxt_xin_prev = pin_sync_ff[7];
        div_tick     = (osc_ff == PAMX_OSC_RC) ? (pin_sync_ff[7] && !xin_prev_ff)
                                               : 1'b1;
        nxt_div_cnt  = div_cnt_ff;
        nxt_clk_out  = clk_out_ff;

        // cleared while off: new mode starts in phase
        if (!pamx_clkout_on(osc_ff)) begin
            nxt_div_cnt = 2'h0;
            nxt_clk_out = 1'b0;
        end else if (div_tick) begin
            if (div_cnt_ff == `PAMX_CLK_DIV - 2'h1) begin
                nxt_div_cnt = 2'h0;
                nxt_clk_out = !clk_out_ff;
            end else begin
                nxt_div_cnt = div_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xin_prev_ff <= 1'b0;
            div_cnt_ff  <= 2'h0;
            clk_out_ff  <= 1'b0;
        end else begin
            xin_prev_ff <= nxt_xin_prev;
            div_cnt_ff  <= nxt_div_cnt;
            clk_out_ff  <= nxt_clk_out;
        end
    end

    // registered pin drive; one cycle after any source or setting changes
    // pads see flops only, no comb glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff   <= 8'h00;
            pin_oe_ff    <= 8'h00;
            ext_clk_ff   <= 1'b0;
            dac_conn_ff  <= 1'b0;
            xtal_conn_ff <= 1'b0;
        end else begin
            pin_out_ff   <= arb_val;
            pin_oe_ff    <= arb_oe;

            // clock input ignores the direction bit entirely
            ext_clk_ff   <= pamx_is_external(osc_ff) && pin_sync_ff[7];
            dac_conn_ff  <= arb_dac;
            xtal_conn_ff <= arb_xtal;
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign port_a_pin_out       = pin_out_ff;
    assign port_a_pin_oe        = pin_oe_ff;
    assign external_clock_in    = ext_clk_ff;
    assign dac_output_connect   = dac_conn_ff;
    assign crystal_out_connect  = xtal_conn_ff;
    assign port_a_analog_enable = ansel_ff;
    assign slew_rate_limit      = slew_ff[4:0];

endmodule : pamx_top

// ### src/pamx_map.svh
// register map, field positions, reset values and masks of the port a pin mux
// assumes 32-bit apb data, one aligned word per register
`ifndef PAMX_MAP_SVH
`define PAMX_MAP_SVH

`define PAMX_ADDR_W          8
`define PAMX_OFF_ANSEL       8'h00
`define PAMX_OFF_PINS        8'h04
`define PAMX_OFF_LATCH       8'h08
`define PAMX_OFF_DIR         8'h0C
`define PAMX_OFF_SLEW        8'h10
`define PAMX_OFF_OSC         8'h14
`define PAMX_OFF_STATUS      8'h18

`define PAMX_ANSEL_MASK      8'h2F
`define PAMX_SLEW_MASK       8'h1F
`define PAMX_ANSEL_RST       8'h2F
`define PAMX_LATCH_RST       8'h00
`define PAMX_DIR_RST         8'hFF
`define PAMX_SLEW_RST        8'h1F

`define PAMX_OSC_MODE_LSB    0
`define PAMX_OSC_MODE_W      2
`define PAMX_OSC_MODE_RST    2'h0

`define PAMX_STAT_CLKOUT_BIT 0
`define PAMX_STAT_EXT_BIT    1
`define PAMX_STAT_DAC_BIT    2

`define PAMX_CLK_DIV         2'h2

`endif

// ### src/pamx_pkg.sv
// types and mode decoding shared by the port a pin mux files
// assumes nothing beyond the map header
package pamx_pkg;

    typedef enum logic [1:0] {
        PAMX_OSC_INT,
        PAMX_OSC_INT_CLKOUT,
        PAMX_OSC_RC,
        PAMX_OSC_XTAL
    } pamx_osc_mode_t;

    function automatic logic pamx_is_external(input pamx_osc_mode_t m);
        return (m == PAMX_OSC_RC) || (m == PAMX_OSC_XTAL);
    endfunction : pamx_is_external

    function automatic logic pamx_clkout_on(input pamx_osc_mode_t m);
        return (m == PAMX_OSC_RC) || (m == PAMX_OSC_INT_CLKOUT);
    endfunction : pamx_clkout_on

endpackage : pamx_pkg

// ### src/pamx_pin_arb.sv
// fixed-priority output arbitration and input gating for the eight port a pins
// assumes all sources come from logic on the same clock; purely combinational
module pamx_pin_arb (
    input  wire logic                    [7:0] latch,
    input  wire logic                    [7:0] dir,
    input  wire logic                    [7:0] ansel,
    input  pamx_pkg::pamx_osc_mode_t           osc_mode,
    input  wire logic                          clk_out_level,
    input  wire logic                          dac_output_en,
    input  wire logic                          sr_latch_q,
    input  wire logic                          sr_latch_q_en,
    input  wire logic                          sr_latch_q_inverted,
    input  wire logic                          sr_latch_q_inverted_en,
    input  wire logic                          comparator1_output,
    input  wire logic                          comparator1_output_en,
    input  wire logic                          comparator2_output,
    input  wire logic                          comparator2_output_en,
    output logic                         [7:0] pin_val,
    output logic                         [7:0] pin_oe,
    output logic                         [7:0] dig_in_en,
    output logic                               dac_connect,
    output logic                               xtal_out_connect
);
    import pamx_pkg::*;

    logic ext;
    logic xtal;

    always_comb begin
        ext              = pamx_is_external(osc_mode);
        xtal             = (osc_mode == PAMX_OSC_XTAL);
        // analog select never enters arbitration; a digital source still wins
        pin_val          = latch;
        pin_oe           = ~dir;
        dac_connect      = 1'b0;
        xtal_out_connect = 1'b0;
        dig_in_en        = dir & ~ansel;
        // bit 2: dac above latch
        if (dac_output_en) begin
            pin_oe[2]    = 1'b0;
            pin_val[2]   = 1'b0;
            dac_connect  = 1'b1;
            dig_in_en[2] = 1'b0;
        end
        // bit 4: sr q, then comparator 1, then latch
        if (sr_latch_q_en) begin
            pin_oe[4]  = 1'b1;
            pin_val[4] = sr_latch_q;
        end else if (comparator1_output_en) begin
            pin_oe[4]  = 1'b1;
            pin_val[4] = comparator1_output;
        end
        // bit 5: sr q inverted, then comparator 2, then latch
        if (sr_latch_q_inverted_en) begin
            pin_oe[5]  = 1'b1;
            pin_val[5] = sr_latch_q_inverted;
        end else if (comparator2_output_en) begin
            pin_oe[5]  = 1'b1;
            pin_val[5] = comparator2_output;
        end
        // bit 6: crystal out, then clock out, then latch (internal only)
        if (xtal) begin
            pin_oe[6]        = 1'b0;
            pin_val[6]       = 1'b0;
            xtal_out_connect = 1'b1;
            dig_in_en[6]     = 1'b0;
        end else if (pamx_clkout_on(osc_mode)) begin
            pin_oe[6]    = 1'b1;
            pin_val[6]   = clk_out_level;
            dig_in_en[6] = 1'b0;
        end
        // bit 7: crystal in owns the pin in every external mode
        if (ext) begin
            pin_oe[7]    = 1'b0;
            pin_val[7]   = 1'b0;
            dig_in_en[7] = 1'b0;
        end
    end

endmodule : pamx_pin_arb

// ### verification/pamx_monitor.sv
// checker of the port a pin mux top module ports
// assumes zero wait state apb; shadows config writes to know the modes
`include "pamx_map.svh"
module pamx_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  port_a_pin_out,
    input wire logic [7:0]  port_a_pin_oe,
    input wire logic        dac_output_en,
    input wire logic        sr_latch_q,
    input wire logic        sr_latch_q_en,
    input wire logic        comparator1_output,
    input wire logic        comparator1_output_en,
    input wire logic        external_clock_in,
    input wire logic        dac_output_connect,
    input wire logic [7:0]  port_a_analog_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lat_ff, nxt_lat, dir_ff, nxt_dir;
    logic [1:0] osc_ff, nxt_osc;
    logic       wr_ok;
    // shadow updates on the same edge the write lands
    always_comb begin
        wr_ok = psel && penable && pready && pwrite && !pslverr;
        nxt_lat = lat_ff;
        nxt_dir = dir_ff;
        nxt_osc = osc_ff;
        if (wr_ok && (paddr[7:0] == `PAMX_OFF_PINS || paddr[7:0] == `PAMX_OFF_LATCH)) begin
            nxt_lat = pwdata[7:0];
        end
        if (wr_ok && paddr[7:0] == `PAMX_OFF_DIR) begin
            nxt_dir = pwdata[7:0];
        end
        if (wr_ok && paddr[7:0] == `PAMX_OFF_OSC) begin
            nxt_osc = pwdata[1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_ff <= 8'h00;
            dir_ff <= 8'hFF;
            osc_ff <= 2'h0;
        end else begin
            lat_ff <= nxt_lat;
            dir_ff <= nxt_dir;
            osc_ff <= nxt_osc;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // pins lag config by one register stage, so config must hold two samples
    sequence s_cfg_held;
        $stable(osc_ff) && $stable(dir_ff) && $stable(lat_ff);
    endsequence
    a_pready_pulse: assert property (s_setup |=> pready ##1 !pready) else $error("pready timing");
    a_slverr_unmapped: assert property (s_setup ##0 (paddr[31:8] != 24'h0) |=>
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    a_bit7_drive: assert property (s_cfg_held ##0 (!osc_ff[1] && !dir_ff[7]) |->
        port_a_pin_oe[7] && port_a_pin_out[7] == lat_ff[7]) else $error("bit 7 not driven");
    a_bit7_release: assert property (s_cfg_held ##0 osc_ff[1] |-> !port_a_pin_oe[7])
        else $error("bit 7 driven in external mode");
    a_clkin_gated: assert property (s_cfg_held ##0 !osc_ff[1] |-> !external_clock_in)
        else $error("clock input active in internal mode");
    a_srq_first: assert property (sr_latch_q_en |=> port_a_pin_oe[4] &&
        port_a_pin_out[4] == $past(sr_latch_q)) else $error("bit 4 not sr latch");
    a_cmp1_second: assert property (!sr_latch_q_en && comparator1_output_en |=>
        port_a_pin_oe[4] && port_a_pin_out[4] == $past(comparator1_output))
        else $error("bit 4 not comparator");
    a_dac_owns: assert property (dac_output_en |=>
        dac_output_connect && !port_a_pin_oe[2]) else $error("bit 2 not given to dac");
    a_analog_mask: assert property ((port_a_analog_enable & 8'hD0) == 8'h00)
        else $error("analog select on digital-only bit");
endmodule : pamx_monitor

bind pamx_top pamx_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe(port_a_pin_oe), .dac_output_en(dac_output_en), .sr_latch_q(sr_latch_q),
    .sr_latch_q_en(sr_latch_q_en), .comparator1_output(comparator1_output),
    .comparator1_output_en(comparator1_output_en), .external_clock_in(external_clock_in),
    .dac_output_connect(dac_output_connect), .port_a_analog_enable(port_a_analog_enable));

// ### verification/pamx_pin_model.sv
// pad side of port a: each pad shows the device drive or an outside level
// assumes the bench sets outside levels and starts the crystal clock
module pamx_pin_model (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_lvl,
    input  wire logic       osc_run,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div_ff;
    logic [3:0] nxt_div;
    always_comb nxt_div = osc_run ? div_ff + 4'h1 : 4'h0;
    always_ff @(posedge pclk) div_ff <= nxt_div;
    // crystal stands still outside runs; period of sixteen pclk
    always_comb begin
        pin_in = ext_lvl;
        for (int i = 0; i < 8; i++) if (pin_oe[i]) pin_in[i] = pin_out[i];
        if (osc_run && !pin_oe[7]) pin_in[7] = div_ff[3];
    end
endmodule : pamx_pin_model

// ### verification/test_port_a_pin_function_mux.sv
// self-checking bench of the port a pin mux over apb
// assumes zero wait state slave and 3 cycle pin input latency
`include "pamx_map.svh"
module test_port_a_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_run = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, q;
    logic        pready, pslverr, last_err, ext_clk, dac_con, xtal_con;
    logic [7:0]  pin_in, pin_out, pin_oe, ana_en, ext_lvl = 8'h00, d;
    logic [4:0]  slew;
    logic [8:0]  per = 0;
    logic [31:0] rng = 32'h45;
    int          err_total = 0, cmp_count = 0, cyc = 0, tg;
    pamx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_pin_in(pin_in), .port_a_pin_out(pin_out),
        .port_a_pin_oe(pin_oe), .dac_output_en(per[0]), .sr_latch_q(per[1]),
        .sr_latch_q_en(per[2]), .sr_latch_q_inverted(per[3]), .sr_latch_q_inverted_en(per[4]),
        .comparator1_output(per[5]), .comparator1_output_en(per[6]),
        .comparator2_output(per[7]), .comparator2_output_en(per[8]),
        .external_clock_in(ext_clk), .dac_output_connect(dac_con),
        .crystal_out_connect(xtal_con), .port_a_analog_enable(ana_en), .slew_rate_limit(slew));
    pamx_pin_model u_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_lvl(ext_lvl), .osc_run(osc_run), .pin_in(pin_in));
    always #2.5 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // {oe5,out5,oe4,out4,oe2,out2}, drive value only meaningful while driven
    function automatic logic [5:0] exp_pr(input logic [8:0] p, input logic [7:0] l, dr);
        logic [5:0] e;
        e[1:0] = p[0] ? 2'b00 : {!dr[2], l[2] & !dr[2]};
        e[3:2] = p[2] ? {1'b1, p[1]} : p[6] ? {1'b1, p[5]} : {!dr[4], l[4] & !dr[4]};
        e[5:4] = p[4] ? {1'b1, p[3]} : p[8] ? {1'b1, p[7]} : {!dr[5], l[5] & !dr[5]};
        return e;
    endfunction : exp_pr
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one edge idles after each transfer so no strobe is assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a} | ((a == 8'hFF) ? 32'h100 : 32'h0);
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    localparam logic [7:0] OFFS [5] = '{`PAMX_OFF_ANSEL, `PAMX_OFF_LATCH, `PAMX_OFF_DIR,
                                        `PAMX_OFF_SLEW, `PAMX_OFF_OSC};
    localparam logic [7:0] RSTS [5] = '{8'h2F, 8'h00, 8'hFF, 8'h1F, 8'h00};
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(0, OFFS[i], 0);
            check(q, RSTS[i]);
        end
        check({ana_en, 3'h0, slew}, 16'h2F1F);
        apb(1, `PAMX_OFF_ANSEL, 32'hFFFFFFFF);
        apb(0, `PAMX_OFF_ANSEL, 0);
        check(q, 32'h2F);
        apb(1, `PAMX_OFF_SLEW, 32'hFFFFFFFF);
        apb(0, `PAMX_OFF_SLEW, 0);
        check(q, 32'h1F);
        for (int i = 0; i < 2; i++) begin
            apb(0, i ? 8'hFF : 8'h1C, 0);
            check({last_err, q}, 33'h100000000);
        end
        $display("register test done");
        ext_lvl <= 8'hC0;
        apb(1, `PAMX_OFF_LATCH, 32'hC0);
        for (int k = 0; k < 8; k++) begin
            d = k[2] ? 8'hFF : 8'h3F;
            apb(1, `PAMX_OFF_DIR, {24'h0, d});
            apb(1, `PAMX_OFF_OSC, k % 4);
            repeat (4) @(posedge pclk);
            check(pin_oe[7], !k[2] && k % 4 < 2);
            check(ext_clk, k % 4 >= 2);
            check(xtal_con, k % 4 == 3);
            if (!k[2] && k % 4 < 3) check({pin_oe[6], pin_out[6] | k % 4 > 0}, 2'b11);
            apb(0, `PAMX_OFF_PINS, 0);
            check(q[7:6], {k[2] && k % 4 < 2, k[2] && k % 4 == 0});
        end
        $display("oscillator test done");
        osc_run <= 1'b1;
        apb(1, `PAMX_OFF_OSC, 2);
        tg = 0;
        repeat (256) begin
            @(posedge pclk);
            if (pin_out[6] !== u_pins.pin_out[6] || $isunknown(pin_out[6])) tg = 99;
            if (pin_out[6] != d[0]) tg++;
            d[0] = pin_out[6];
        end
        check(tg inside {[7:9]}, 1);
        apb(0, `PAMX_OFF_STATUS, 0);
        check(q[2:1], 2'b01);
        osc_run <= 1'b0;
        apb(1, `PAMX_OFF_OSC, 0);
        for (int k = 0; k < 2; k++) begin
            rng = xs(rng);
            ext_lvl <= rng[7:0];
            apb(1, `PAMX_OFF_ANSEL, k ? 32'h0 : 32'hFF);
            repeat (4) @(posedge pclk);
            apb(0, `PAMX_OFF_PINS, 0);
            check(q, rng[7:0] & (k ? 8'hFF : 8'hD0));
        end
        $display("input gating test done");
        apb(1, `PAMX_OFF_ANSEL, 32'hFF);
        for (int k = 0; k < 40; k++) begin
            rng = xs(rng);
            per <= (k < 4) ? 9'h1FF >> (2 * k) : rng[8:0];
            apb(1, k[0] ? `PAMX_OFF_PINS : `PAMX_OFF_LATCH, {24'h0, rng[23:16]});
            apb(1, `PAMX_OFF_DIR, {24'h0, rng[31:24]});
            @(posedge pclk);
            check({pin_oe[5], pin_out[5] & pin_oe[5], pin_oe[4], pin_out[4] & pin_oe[4],
                   pin_oe[2], pin_out[2] & pin_oe[2]}, exp_pr(per, rng[23:16], rng[31:24]));
            check(dac_con, per[0]);
            apb(0, `PAMX_OFF_STATUS, 0);
            check(q, {29'h0, per[0], 2'b00});
        end
        per <= 9'h0;
        $display("priority test done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `PAMX_OFF_DIR, 0);
        check(q, 32'hFF);
        $display("second reset test done");
        final_report();
    end
endmodule : test_port_a_pin_function_mux
